// ### hdl/sample_record_group_builder.sv
// configuration register and record assembler for adaptive precise sampling records
`timescale 1ns/1ps
`default_nettype none
`include "record_builder_regs.svh"
module sample_record_group_builder
    import record_builder_pkg::*;
#(
    parameter int GEN_COUNTERS = 16,
    parameter int FIX_COUNTERS = 8,
    parameter int BRANCH_IMPL = 32
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // configuration register write and readback
    input wire logic cfg_wr_i,
    input wire logic [63:0] cfg_wdata_i,
    output logic [63:0] cfg_rdata_o,
    output logic general_protection_fault_o,
    // processor capability and mode
    input wire logic monitoring_available_i,
    input wire logic metrics_available_i,
    input wire logic [GEN_COUNTERS-1:0] general_counter_present_i,
    input wire logic [FIX_COUNTERS-1:0] fixed_counter_present_i,
    input wire logic mode64_i,
    input wire logic [7:0] branch_stack_top_i,
    // record request
    input wire logic sample_req_i,
    output logic busy_o,
    // source data fetch, answered in the same cycle
    output src_group_t src_group_o,
    output logic [7:0] src_index_o,
    output logic [1:0] src_word_o,
    input wire logic [63:0] src_data_i,
    // record word stream toward the sampling buffer
    output logic rec_valid_o,
    output logic [63:0] rec_data_o,
    output logic rec_last_o,
    input wire logic rec_ready_i,
    output logic [15:0] rec_bytes_o,
    output logic [15:0] cnt_group_bytes_o,
    // clears topdown metric register and fourth fixed counter
    output logic metrics_clear_o
);

    // ---------------- configuration register ----------------
    logic [63:0] cfg_r; // software visible configuration
    logic [63:0] cfg_nxt;
    logic fault_r; // one-cycle fault pulse
    wire wr_live = cfg_wr_i && monitoring_available_i;
    wire wr_bad = wr_live && ((cfg_wdata_i & `CFG_RESERVED_MASK) != 64'h0);

    // writable mask: capability bits limit what sticks
    logic [63:0] wr_mask;
    always_comb begin
        wr_mask = 64'h0000_0000_FF00_001F;
        wr_mask[`CFG_METRICS_BIT] = metrics_available_i;
        wr_mask[`CFG_GEN_LSB +: GEN_COUNTERS] = general_counter_present_i;
        wr_mask[`CFG_FIX_LSB +: FIX_COUNTERS] = fixed_counter_present_i;
    end
    assign cfg_nxt = cfg_wdata_i & wr_mask;

    // register update; a faulting write leaves the old value
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cfg_r <= `CFG_RESET;
            fault_r <= 1'b0;
        end else begin
            fault_r <= wr_bad;
            if (wr_live && !wr_bad) begin
                cfg_r <= cfg_nxt;
            end
        end
    end
    assign cfg_rdata_o = cfg_r;
    assign general_protection_fault_o = fault_r;

    // ---------------- record geometry ----------------
    build_state_t state_r;
    logic [63:0] act_cfg_r; // snapshot so a mid-record write cannot tear it
    wire idle = (state_r == ST_IDLE);
    wire [63:0] use_cfg = idle ? cfg_r : act_cfg_r;

    wire en_mem = use_cfg[`CFG_MEM_BIT];
    wire en_gpr = use_cfg[`CFG_GPR_BIT];
    wire en_vec = use_cfg[`CFG_VEC_BIT];
    wire en_br = use_cfg[`CFG_BRANCH_BIT];
    wire en_cnt = use_cfg[`CFG_COUNTERS_BIT];
    wire en_met = use_cfg[`CFG_METRICS_BIT];
    wire en_grp = en_cnt || en_met;

    // header vectors, zero-extended to 32 bits
    wire [15:0] gen_vec = en_cnt ? use_cfg[`CFG_GEN_MSB:`CFG_GEN_LSB] : 16'h0000;
    wire [7:0] fix_vec = en_cnt ? use_cfg[`CFG_FIX_MSB:`CFG_FIX_LSB] : 8'h00;
    wire met_on = en_met && use_cfg[`CFG_FIX3_BIT];
    wire [31:0] met_vec = met_on ? `METRICS_VECTOR_BOTH : 32'h0000_0000;

    // entry count is field plus one, up to 256
    wire [8:0] br_entries = {1'b0, use_cfg[`CFG_ENTRY_MSB:`CFG_ENTRY_LSB]} + 9'h001;
    wire [10:0] br_words = 11'(br_entries) * 11'h003;

    logic [4:0] vec_pop;
    bit_population #(
        .WIDTH(26),
        .CW(5)
    ) u_pop (
        .bits_i({met_vec[1:0], fix_vec, gen_vec}),
        .count_o(vec_pop)
    );

    // group bytes = 16 + 8 per set vector bit
    wire [15:0] cnt_bytes = 16'h0010 + {8'h00, vec_pop, 3'b000};

    // record size sums only the groups selected, no padding between them
    wire [15:0] rec_bytes_calc = 16'h0020
        + (en_mem ? 16'h0020 : 16'h0000)
        + (en_gpr ? 16'h0090 : 16'h0000)
        + (en_vec ? 16'h0100 : 16'h0000)
        + (en_br ? {2'b00, br_words, 3'b000} : 16'h0000)
        + (en_grp ? cnt_bytes : 16'h0000);

    // ---------------- sequencer ----------------
    logic [9:0] idx_r; // word or slot index inside the group
    logic [1:0] sub_r; // word within a branch entry
    logic [7:0] slot_r; // branch stack slot being read
    logic [12:0] words_left_r; // words still to emit in this record
    logic [15:0] rec_bytes_r;
    logic [15:0] cnt_bytes_r;
    logic out_valid_r;
    logic [63:0] out_data_r;
    logic out_last_r;
    logic clear_r;

    wire advance = !out_valid_r || rec_ready_i; // output slot free

    // length of the current group in steps
    logic [9:0] grp_len;
    always_comb begin
        case (state_r)
            ST_BASIC: grp_len = `BASIC_WORDS;
            ST_MEM: grp_len = `MEM_WORDS;
            ST_GPR: grp_len = `GPR_WORDS;
            ST_VEC: grp_len = `VEC_WORDS;
            ST_BRANCH: grp_len = br_words[9:0];
            ST_CNT_HDR: grp_len = `CNT_HDR_WORDS;
            ST_CNT_VAL: grp_len = `CNT_SLOTS;
            default: grp_len = 10'h001;
        endcase
    end
    wire grp_end = (idx_r == grp_len - 10'h001);

    // next selected group after the current one, fixed order
    build_state_t nxt_grp;
    always_comb begin
        nxt_grp = ST_IDLE;
        case (state_r)
            ST_BASIC: nxt_grp = en_mem ? ST_MEM : en_gpr ? ST_GPR : en_vec ? ST_VEC
                : en_br ? ST_BRANCH : en_grp ? ST_CNT_HDR : ST_IDLE;
            ST_MEM: nxt_grp = en_gpr ? ST_GPR : en_vec ? ST_VEC
                : en_br ? ST_BRANCH : en_grp ? ST_CNT_HDR : ST_IDLE;
            ST_GPR: nxt_grp = en_vec ? ST_VEC : en_br ? ST_BRANCH : en_grp ? ST_CNT_HDR : ST_IDLE;
            ST_VEC: nxt_grp = en_br ? ST_BRANCH : en_grp ? ST_CNT_HDR : ST_IDLE;
            ST_BRANCH: nxt_grp = en_grp ? ST_CNT_HDR : ST_IDLE;
            ST_CNT_HDR: nxt_grp = ST_CNT_VAL;
            default: nxt_grp = ST_IDLE;
        endcase
    end

    // counter slot scan: general, then fixed, then metric words
    logic slot_set;
    always_comb begin
        if (idx_r < `SLOT_FIX_FIRST) begin
            slot_set = gen_vec[idx_r[3:0]];
        end else if (idx_r < `SLOT_MET_FIRST) begin
            slot_set = fix_vec[idx_r[2:0]];
        end else begin
            slot_set = met_vec[idx_r[0]];
        end
    end

    // register-mode zeroing outside 64-bit mode
    wire gpr_zero_hi = (state_r == ST_GPR) && !mode64_i
        && (idx_r >= `GPR_LEGACY_FIRST) && (idx_r <= `GPR_LEGACY_LAST);
    wire gpr_zero_all = (state_r == ST_GPR) && !mode64_i && (idx_r >= `GPR_EXT_FIRST);
    wire vec_zero = (state_r == ST_VEC) && !mode64_i && (idx_r >= `VEC_EXT_FIRST);

    // word to emit this step
    logic emit;
    logic [63:0] cur_word;
    always_comb begin
        emit = 1'b0;
        cur_word = src_data_i;
        case (state_r)
            ST_BASIC, ST_MEM, ST_GPR, ST_VEC, ST_BRANCH: begin
                emit = 1'b1;
                if (gpr_zero_all || vec_zero) begin
                    cur_word = 64'h0;
                end else if (gpr_zero_hi) begin
                    cur_word = {32'h0000_0000, src_data_i[31:0]};
                end
            end
            ST_CNT_HDR: begin
                emit = 1'b1;
                // first word: general then fixed vector; second: metrics then reserved
                cur_word = (idx_r == 10'h000) ? {24'h000000, fix_vec, 16'h0000, gen_vec}
                    : {32'h0000_0000, met_vec};
            end
            ST_CNT_VAL: begin
                emit = slot_set; // unset slots take a cycle but no space
            end
            default: begin
                emit = 1'b0;
            end
        endcase
    end

    // fetch port addressing
    always_comb begin
        src_index_o = idx_r[7:0];
        src_word_o = 2'b00;
        case (state_r)
            ST_BASIC: src_group_o = SRC_BASIC;
            ST_MEM: src_group_o = SRC_MEM;
            ST_GPR: src_group_o = SRC_GPR;
            ST_VEC: src_group_o = SRC_VEC;
            ST_BRANCH: begin
                src_group_o = SRC_BRANCH;
                src_index_o = slot_r;
                src_word_o = sub_r;
            end
            ST_CNT_VAL: src_group_o = SRC_COUNTER;
            default: src_group_o = SRC_NONE;
        endcase
    end

    // stepping wrap for the branch stack walk
    wire [7:0] slot_dec = (slot_r == 8'h00) ? 8'(BRANCH_IMPL - 1) : slot_r - 8'h01;
    wire [7:0] top_mod = (branch_stack_top_i >= 8'(BRANCH_IMPL))
        ? branch_stack_top_i - 8'(BRANCH_IMPL) : branch_stack_top_i;
    wire met_data_go = (state_r == ST_CNT_VAL) && (idx_r == `SLOT_MET_DATA) && met_vec[1] && advance;

    // sequencer state and counters
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            act_cfg_r <= `CFG_RESET;
            idx_r <= 10'h000;
            sub_r <= 2'b00;
            slot_r <= 8'h00;
            words_left_r <= 13'h0000;
            rec_bytes_r <= 16'h0000;
            cnt_bytes_r <= 16'h0000;
        end else if (idle) begin
            if (sample_req_i) begin
                state_r <= ST_BASIC;
                act_cfg_r <= cfg_r;
                idx_r <= 10'h000;
                sub_r <= 2'b00;
                slot_r <= top_mod;
                words_left_r <= rec_bytes_calc[15:3];
                rec_bytes_r <= rec_bytes_calc;
                cnt_bytes_r <= en_grp ? cnt_bytes : 16'h0000;
            end
        end else if (advance) begin
            if (emit) begin
                words_left_r <= words_left_r - 13'h0001;
            end
            if (state_r == ST_BRANCH) begin
                // three words per entry, then step down the stack
                if (sub_r == 2'b10) begin
                    sub_r <= 2'b00;
                    slot_r <= slot_dec;
                end else begin
                    sub_r <= sub_r + 2'b01;
                end
            end
            if (grp_end) begin
                state_r <= nxt_grp;
                idx_r <= 10'h000;
            end else begin
                idx_r <= idx_r + 10'h001;
            end
        end
    end

    // output word register and metrics clear pulse
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            out_valid_r <= 1'b0;
            out_data_r <= 64'h0;
            out_last_r <= 1'b0;
            clear_r <= 1'b0;
        end else begin
            // clear only once the metric data word has been taken into the record
            clear_r <= met_data_go;
            if (advance) begin
                out_valid_r <= emit;
                out_data_r <= emit ? cur_word : out_data_r;
                out_last_r <= emit && (words_left_r == 13'h0001);
            end
        end
    end

    assign busy_o = !idle || out_valid_r;
    assign rec_valid_o = out_valid_r;
    assign rec_data_o = out_data_r;
    assign rec_last_o = out_last_r;
    assign rec_bytes_o = rec_bytes_r;
    assign cnt_group_bytes_o = cnt_bytes_r;
    assign metrics_clear_o = clear_r;

endmodule
`default_nettype wire

// ### hdl/record_builder_regs.svh
// register layout, field positions and record geometry for the sampling record group builder
// How it works
// - basic group always heads every record
// - config bit 0 adds memory group
// - config bit 1 adds general register group
// - config bit 2 adds vector register group
// - config bit 3 adds branch history entries
// - branch entries equal count field plus one
// - config bit 4 enables counter value capture
// - bit 5 records/clears metrics with fourth fixed
// - bits 47:32 general mask, present bits only
// - bits 55:48 fixed mask, present bits only
// - reserved bit write faults, no update
// - writes ignored while monitoring unavailable
// - counters group when counters or metrics set
// - header: general, fixed, metrics, reserved words
// - general counter x needs counters and bit 32+x
// - fixed counter x needs counters and bit 48+x
// - metrics need metrics and bit 51; vector 3
// - clear metric register and fourth fixed afterwards
// - values follow: general, fixed, then metrics
// - metrics bit0 base value, bit1 metric register
// - counters group bytes 16 plus 8 per bit
// - unselected groups absent, groups packed tightly
// - branch entries from stack top, wrapping downward
// - outside 64-bit mode zero upper/extended registers
`ifndef RECORD_BUILDER_REGS_SVH
`define RECORD_BUILDER_REGS_SVH

// configuration register fields
`define CFG_RESET 64'h0000_0000_0000_0000
`define CFG_RESERVED_MASK 64'hFF00_0000_00FF_FFC0
`define CFG_MEM_BIT 0
`define CFG_GPR_BIT 1
`define CFG_VEC_BIT 2
`define CFG_BRANCH_BIT 3
`define CFG_COUNTERS_BIT 4
`define CFG_METRICS_BIT 5
`define CFG_ENTRY_LSB 24
`define CFG_ENTRY_MSB 31
`define CFG_GEN_LSB 32
`define CFG_GEN_MSB 47
`define CFG_FIX_LSB 48
`define CFG_FIX_MSB 55
`define CFG_FIX3_BIT 51

// group lengths in 64-bit words
`define BASIC_WORDS 10'h004
`define MEM_WORDS 10'h004
`define GPR_WORDS 10'h012
`define VEC_WORDS 10'h020
`define BRANCH_ENTRY_WORDS 10'h003
`define CNT_HDR_WORDS 10'h002
`define CNT_SLOTS 10'h01A
`define METRICS_VECTOR_BOTH 32'h0000_0003

// general and vector register word ranges
`define GPR_LEGACY_FIRST 10'h002
`define GPR_LEGACY_LAST 10'h009
`define GPR_EXT_FIRST 10'h00A
`define VEC_EXT_FIRST 10'h010

// counter slot numbering inside the value scan
`define SLOT_FIX_FIRST 10'h010
`define SLOT_MET_FIRST 10'h018
`define SLOT_MET_DATA 10'h019

`endif

// ### hdl/record_builder_pkg.sv
// types shared by the sampling record group builder
package record_builder_pkg;

    // assembly sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_BASIC = 8'h02,
        ST_MEM = 8'h04,
        ST_GPR = 8'h08,
        ST_VEC = 8'h10,
        ST_BRANCH = 8'h20,
        ST_CNT_HDR = 8'h40,
        ST_CNT_VAL = 8'h80
    } build_state_t;

    // source group selector presented to the data fetch port
    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_BASIC = 3'h1,
        SRC_MEM = 3'h2,
        SRC_GPR = 3'h3,
        SRC_VEC = 3'h4,
        SRC_BRANCH = 3'h5,
        SRC_COUNTER = 3'h6
    } src_group_t;

endpackage

// ### hdl/bit_population.sv
// population count of a bit vector
`timescale 1ns/1ps
`default_nettype none
module bit_population #(
    parameter int WIDTH = 26,
    parameter int CW = 5
) (
    // vector in
    input wire logic [WIDTH-1:0] bits_i,
    // number of set bits
    output logic [CW-1:0] count_o
);
    // plain adder chain; width is small so depth is harmless
    always_comb begin
        count_o = '0;
        for (int i = 0; i < WIDTH; i++) begin
            count_o = count_o + CW'(bits_i[i]);
        end
    end
endmodule
`default_nettype wire

// ### test/record_builder_checker_assertions.sv
// concurrent port checks for the sampling record group builder
`timescale 1ns/1ps
`default_nettype none
`include "record_builder_regs.svh"
module record_builder_checker
    import record_builder_pkg::*;
#(
    parameter int GEN_COUNTERS = 16,
    parameter int FIX_COUNTERS = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // configuration side
    input wire logic cfg_wr_i,
    input wire logic [63:0] cfg_wdata_i,
    input wire logic [63:0] cfg_rdata_o,
    input wire logic general_protection_fault_o,
    input wire logic monitoring_available_i,
    input wire logic metrics_available_i,
    input wire logic [GEN_COUNTERS-1:0] general_counter_present_i,
    input wire logic [FIX_COUNTERS-1:0] fixed_counter_present_i,
    // record side
    input wire logic sample_req_i,
    input wire logic busy_o,
    input wire src_group_t src_group_o,
    input wire logic [7:0] src_index_o,
    input wire logic rec_valid_o,
    input wire logic [63:0] rec_data_o,
    input wire logic rec_last_o,
    input wire logic rec_ready_i,
    input wire logic [15:0] cnt_group_bytes_o,
    input wire logic metrics_clear_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // write touches a reserved bit
    wire bad_bits = |(cfg_wdata_i & `CFG_RESERVED_MASK);
    // value a clean write leaves; absent counters and metrics read back zero
    wire [63:0] kept = {8'h00, cfg_wdata_i[55:48] & fixed_counter_present_i,
        cfg_wdata_i[47:32] & general_counter_present_i, cfg_wdata_i[31:24], 18'h00000,
        cfg_wdata_i[5] & metrics_available_i, cfg_wdata_i[4:0]};
    a_reset_cfg_zero: assert property ($rose(rst_n_i) |-> cfg_rdata_o == 64'h0)
        else $error("config not zero after reset");
    a_fault_no_update: assert property (cfg_wr_i && monitoring_available_i && bad_bits
        |=> general_protection_fault_o && $stable(cfg_rdata_o)) else $error("reserved write not refused");
    a_ignore_unavailable: assert property (cfg_wr_i && !monitoring_available_i
        |=> !general_protection_fault_o && $stable(cfg_rdata_o)) else $error("write taken while unavailable");
    a_write_masked: assert property (cfg_wr_i && monitoring_available_i && !bad_bits
        |=> !general_protection_fault_o && cfg_rdata_o == $past(kept)) else $error("clean write wrong value");
    a_word_holds: assert property (rec_valid_o && !rec_ready_i
        |=> rec_valid_o && $stable(rec_data_o) && $stable(rec_last_o)) else $error("record word dropped");
    a_basic_first: assert property (sample_req_i && !busy_o
        |=> src_group_o == SRC_BASIC && src_index_o == 8'h00) else $error("record not opened by basic group");
    a_clear_pulse: assert property (metrics_clear_o
        |-> cfg_rdata_o[5] && cfg_rdata_o[51] && !$past(metrics_clear_o)) else $error("stray metrics clear");
    a_last_ends: assert property (rec_valid_o && rec_ready_i && rec_last_o |=> !rec_valid_o)
        else $error("word after record end");
    a_group_size: assert property (cnt_group_bytes_o == 16'h0000 || (cnt_group_bytes_o[2:0] == 3'h0
        && cnt_group_bytes_o inside {[16'h0010:16'h00E0]})) else $error("counters group size off");
endmodule
bind sample_record_group_builder record_builder_checker #(.GEN_COUNTERS(GEN_COUNTERS), .FIX_COUNTERS(FIX_COUNTERS))
    u_checker (.core_clk_i, .rst_n_i, .cfg_wr_i, .cfg_wdata_i, .cfg_rdata_o, .general_protection_fault_o,
    .monitoring_available_i, .metrics_available_i, .general_counter_present_i, .fixed_counter_present_i,
    .sample_req_i, .busy_o, .src_group_o, .src_index_o, .rec_valid_o, .rec_data_o, .rec_last_o,
    .rec_ready_i, .cnt_group_bytes_o, .metrics_clear_o);
`default_nettype wire

// ### test/far_side_model.sv
// far side: same-cycle data source and a record sink that stalls
`timescale 1ns/1ps
`default_nettype none
module far_side_model
    import record_builder_pkg::*;
(
    // clock
    input wire logic core_clk_i,
    // fetch port
    input wire src_group_t src_group_i,
    input wire logic [7:0] src_index_i,
    input wire logic [1:0] src_word_i,
    output logic [63:0] src_data_o,
    // sink
    input wire logic stall_i,
    output logic rec_ready_o
);
    // unique word per group and slot; word select only matters for branches
    function automatic logic [63:0] pattern(input logic [2:0] g, input logic [7:0] i, input logic [1:0] w);
        logic [1:0] ww;
        ww = (g == 3'h5) ? w : 2'h0;
        return {g, ww, 3'h0, i, 16'hA5C3, 8'h00, ~i, 5'h00, g, 8'h5A};
    endfunction
    // answered combinationally, as the fetch port expects
    assign src_data_o = pattern(src_group_i, src_index_i, src_word_i);
    // random back-pressure only while stalling is asked for; one driver, settled long before reset ends
    always @(posedge core_clk_i) begin
        rec_ready_o <= stall_i ? 1'($urandom_range(0, 1)) : 1'b1;
    end
endmodule
`default_nettype wire

// ### test/sample_record_group_builder_tb.sv
// self-checking bench for the sampling record group builder
`timescale 1ns/1ps
`default_nettype none
`include "record_builder_regs.svh"
module sample_record_group_builder_tb
    import record_builder_pkg::*;
;
    // design inputs, all set at time zero
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, cfg_wr_i = 1'b0, monitoring_available_i = 1'b0;
    logic metrics_available_i = 1'b0, mode64_i = 1'b1, sample_req_i = 1'b0, stall = 1'b0;
    logic [63:0] cfg_wdata_i = 64'h0, cfg_rdata_o, src_data_i, rec_data_o, exp_cfg = 64'h0;
    logic [15:0] general_counter_present_i = 16'hFFFF, rec_bytes_o, cnt_group_bytes_o, exp_cb;
    logic [7:0] fixed_counter_present_i = 8'hFF, branch_stack_top_i = 8'h00, src_index_o;
    // design outputs
    logic general_protection_fault_o, busy_o, rec_valid_o, rec_last_o, rec_ready_i, metrics_clear_o, done;
    src_group_t src_group_o;
    logic [1:0] src_word_o;
    // expected and collected record words
    logic [63:0] exp_q[$], got_q[$];
    int bad_count = 0, n_checks = 0, clr_n = 0;
    int rsv[4] = '{6, 23, 56, 63}; // reserved bit positions, tried one at a time
    sample_record_group_builder u_sample_record_group_builder (.core_clk_i, .rst_n_i, .cfg_wr_i, .cfg_wdata_i,
        .cfg_rdata_o, .general_protection_fault_o, .monitoring_available_i, .metrics_available_i,
        .general_counter_present_i, .fixed_counter_present_i, .mode64_i, .branch_stack_top_i, .sample_req_i,
        .busy_o, .src_group_o, .src_index_o, .src_word_o, .src_data_i, .rec_valid_o, .rec_data_o, .rec_last_o,
        .rec_ready_i, .rec_bytes_o, .cnt_group_bytes_o, .metrics_clear_o);
    far_side_model u_far (.core_clk_i, .src_group_i(src_group_o), .src_index_i(src_index_o),
        .src_word_i(src_word_o), .src_data_o(src_data_i), .stall_i(stall), .rec_ready_o(rec_ready_i));
    // 250 MHz core clock
    always #2 core_clk_i = ~core_clk_i;
    // collect accepted words and clear pulses
    always @(posedge core_clk_i) begin
        if (rst_n_i && rec_valid_o === 1'b1 && rec_ready_i) begin
            got_q.push_back(rec_data_o);
            if (rec_last_o) done <= 1'b1;
        end
        if (metrics_clear_o === 1'b1) clr_n++;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // config readback: absent counters and unavailable metrics store zero
    function automatic logic [63:0] cfg_next(input logic [63:0] d);
        return {8'h00, d[55:48] & fixed_counter_present_i, d[47:32] & general_counter_present_i, d[31:24],
            18'h00000, d[5] & metrics_available_i, d[4:0]};
    endfunction
    // capability and mode levels, changed only between operations
    task automatic caps(input logic mon, input logic met, input logic [15:0] gp, input logic [7:0] fp,
        input logic m64, input logic [7:0] top, input logic st);
        @(posedge core_clk_i);
        monitoring_available_i <= mon;
        metrics_available_i <= met;
        general_counter_present_i <= gp;
        fixed_counter_present_i <= fp;
        mode64_i <= m64;
        branch_stack_top_i <= top;
        stall <= st;
    endtask
    // one config write, then fault and readback one cycle on
    task automatic wr(input logic [63:0] d);
        @(posedge core_clk_i);
        cfg_wr_i <= 1'b1;
        cfg_wdata_i <= d;
        @(posedge core_clk_i);
        cfg_wr_i <= 1'b0;
        if (monitoring_available_i && !(|(d & `CFG_RESERVED_MASK))) exp_cfg = cfg_next(d);
        #1;
        chk(general_protection_fault_o, 64'(monitoring_available_i && |(d & `CFG_RESERVED_MASK)), "fault");
        chk(cfg_rdata_o, exp_cfg, "config");
    endtask
    // predict the record from the config, request it and compare word by word
    task automatic record(input logic [63:0] c);
        logic [15:0] gv;
        logic [7:0] fv;
        logic [31:0] mv;
        logic [63:0] w;
        int n;
        exp_q.delete();
        for (int i = 0; i < 4; i++) exp_q.push_back(u_far.pattern(3'h1, 8'(i), 2'h0));
        if (c[0]) for (int i = 0; i < 4; i++) exp_q.push_back(u_far.pattern(3'h2, 8'(i), 2'h0));
        for (int i = 0; i < 18 && c[1]; i++) begin
            w = u_far.pattern(3'h3, 8'(i), 2'h0);
            if (!mode64_i && i >= 10) w = 64'h0;
            else if (!mode64_i && i >= 2) w[63:32] = 32'h0;
            exp_q.push_back(w);
        end
        for (int i = 0; i < 32 && c[2]; i++)
            exp_q.push_back((!mode64_i && i >= 16) ? 64'h0 : u_far.pattern(3'h4, 8'(i), 2'h0));
        // stack top first, then older entries, wrapping within the slots
        for (int k = 0; k <= int'(c[31:24]) && c[3]; k++)
            for (int j = 0; j < 3; j++)
                exp_q.push_back(u_far.pattern(3'h5, 8'((branch_stack_top_i % 32 - k + 32) % 32), 2'(j)));
        gv = c[4] ? c[47:32] : 16'h0000;
        fv = c[4] ? c[55:48] : 8'h00;
        mv = (c[5] && c[51]) ? `METRICS_VECTOR_BOTH : 32'h0;
        if (c[4] || c[5]) begin
            exp_q.push_back({24'h0, fv, 16'h0, gv});
            exp_q.push_back({32'h0, mv});
            for (int x = 0; x < 16; x++) if (gv[x]) exp_q.push_back(u_far.pattern(3'h6, 8'(x), 2'h0));
            for (int x = 0; x < 8; x++) if (fv[x]) exp_q.push_back(u_far.pattern(3'h6, 8'(16 + x), 2'h0));
            if (mv[0]) exp_q.push_back(u_far.pattern(3'h6, 8'h18, 2'h0));
            if (mv[1]) exp_q.push_back(u_far.pattern(3'h6, 8'h19, 2'h0));
        end
        exp_cb = (c[4] || c[5]) ? 16'(16 + 8 * ($countones(gv) + $countones(fv) + $countones(mv))) : 16'h0000;
        got_q.delete();
        clr_n = 0;
        done = 1'b0;
        for (n = 0; n < 200 && busy_o !== 1'b0; n++) @(negedge core_clk_i);
        @(posedge core_clk_i);
        sample_req_i <= 1'b1;
        @(posedge core_clk_i);
        sample_req_i <= 1'b0;
        for (n = 0; n < 3000 && done !== 1'b1; n++) @(posedge core_clk_i);
        repeat (3) @(posedge core_clk_i);
        #1;
        // a record that never flags its end would otherwise only show as a slow run
        chk(done, 1'b1, "end flag seen");
        chk(got_q.size(), exp_q.size(), "word count");
        foreach (exp_q[i]) chk(got_q[i], exp_q[i], "record word");
        chk(rec_bytes_o, 16'(8 * exp_q.size()), "record bytes");
        chk(cnt_group_bytes_o, exp_cb, "group bytes");
        chk(clr_n, 64'(mv == 32'h3), "metrics clears");
    endtask
    // hang guard, well past the expected run length
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(54));
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        chk(cfg_rdata_o, 64'h0, "reset config");
        record(64'h0);
        wr(64'h0000_0000_0000_001F);
        caps(1'b1, 1'b1, 16'hFFFF, 8'hFF, 1'b1, 8'h03, 1'b1);
        foreach (rsv[b]) wr(64'h1 << rsv[b]);
        // every group, all branch entries wrapping below slot 3
        wr(64'h00FF_FFFF_1F00_003F);
        record(exp_cfg);
        // metrics without the fourth fixed bit, then with it and two branch entries
        wr(64'h0007_0000_0000_0020);
        record(exp_cfg);
        wr(64'h0008_0000_0100_0028);
        record(exp_cfg);
        // random configurations with awkward capability mixes
        for (int it = 0; it < 24; it++) begin
            caps(1'b1, 1'($urandom), 16'($urandom), 8'($urandom), 1'($urandom),
                8'($urandom_range(0, 63)), 1'($urandom));
            // odd entry fields keep the branch group a multiple of 16 bytes
            wr({8'h00, 24'($urandom), 8'($urandom_range(0, 3) * 2 + 1), 18'h0, 6'($urandom)});
            record(exp_cfg);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
